// *** logic/uart0_consts.svh ***
// Register offsets, field positions, reset values and timing counts of serial port 0.
`ifndef UART0_CONSTS_SVH
`define UART0_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_POWER_CONTROL  8'h87
`define OFS_UART_CONTROL   8'h98
`define OFS_UART_BUFFER    8'h99
`define OFS_IRQ_ENABLE     8'hA8
`define OFS_STATION_ADDR   8'hA9
`define OFS_STATION_MASK   8'hB9

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_MODE_HI        7
`define CTL_MODE_LO        6
`define CTL_MP             5
`define CTL_REN            4
`define CTL_TB8            3
`define CTL_RB8            2
`define CTL_TI             1
`define CTL_RI             0
`define PWR_DOUBLER        7
`define PWR_FCE            6
`define IE_GLOBAL          7
`define IE_UART            4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_BYTE           8'h00
`define RST_TX_FRAME       11'h7FF

// ----------------------------------------------------------------------------
// Timing counts in system clocks and oversampling ticks
// ----------------------------------------------------------------------------
`define M0_CLKS_SLOW       12
`define M0_CLKS_FAST       4
`define M2_CLKS_SLOW       64
`define M2_CLKS_FAST       32
`define OS_PER_BIT         16
`define OS_MID             8

`endif

// *** logic/uart0_pkg.sv ***
// Types shared by the serial port 0 modules.
package uart0_pkg;

  typedef logic [1:0] mode_t;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_M0_TX,
    SH_M0_RX,
    SH_ASYNC_TX
  } shift_state_e;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } rx_state_e;

endpackage

// *** logic/serial_timing_if.sv ***
// Interface carrying mode settings and bit-rate ticks between the port modules.
`timescale 1ns/1ps
`default_nettype none

interface serial_timing_if;
  uart0_pkg::mode_t mode;
  logic             mp_bit;
  logic             doubler;
  logic             timer_tick;
  logic             os_tick;
  logic             half_tick;

  modport gen  (input mode, mp_bit, doubler, timer_tick, output os_tick, half_tick);
  modport core (output mode, mp_bit, doubler, timer_tick, input os_tick, half_tick);
  modport rx   (input mode, os_tick);
endinterface

`default_nettype wire

// *** logic/uart0_baud.sv ***
// Bit-rate tick generator for all four serial modes.
`timescale 1ns/1ps
`default_nettype none
`include "uart0_consts.svh"

module uart0_baud (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  serial_timing_if.gen     tif
);

  logic [5:0] div_q;
  logic [5:0] limit;
  logic       odd_q;
  logic       div_wrap;

  // Mode 0 ticks at each half bit; mode 2 ticks sixteen times per bit.
  always_comb begin
    if (tif.mode == 2'b00) begin
      limit = tif.mp_bit ? 6'(`M0_CLKS_FAST / 2) : 6'(`M0_CLKS_SLOW / 2);
    end else begin
      limit = tif.doubler ? 6'(`M2_CLKS_FAST / `OS_PER_BIT)
                          : 6'(`M2_CLKS_SLOW / `OS_PER_BIT);
    end
  end

  assign div_wrap = (div_q >= limit - 6'h01);

  // Free running divider of the system clock.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 6'h00;
    end else if (div_wrap) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // Without the doubler only every second timer pulse counts.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      odd_q <= 1'b0;
    end else if (tif.timer_tick) begin
      odd_q <= ~odd_q;
    end
  end

  // Variable rate modes follow the external timer pulse.
  always_comb begin
    tif.half_tick = (tif.mode == 2'b00) && div_wrap;
    case (tif.mode)
      2'b10:   tif.os_tick = div_wrap;
      2'b01,
      2'b11:   tif.os_tick = tif.timer_tick && (tif.doubler || odd_q);
      default: tif.os_tick = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// *** logic/uart0_rx.sv ***
// Asynchronous receiver with sixteen-fold oversampling.
`timescale 1ns/1ps
`default_nettype none
`include "uart0_consts.svh"

module uart0_rx (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  serial_timing_if.rx      tif,
  input  wire logic        rx_en,
  input  wire logic        rxd,
  output logic             done,
  output logic [7:0]       data,
  output logic             ninth,
  output logic             stop_ok
);

  uart0_pkg::rx_state_e state_q;
  logic [3:0]           os_q;
  logic [3:0]           idx_q;
  logic [8:0]           frame_q;
  logic                 prev_q;
  logic [3:0]           last_idx;

  assign last_idx = tif.mode[1] ? 4'd9 : 4'd8;

  // Falling edge detect on the line.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= rxd;
    end
  end

  // Frame sequencer; a start bit that is high at its middle is a glitch.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= uart0_pkg::RX_IDLE;
      os_q    <= 4'h0;
      idx_q   <= 4'h0;
      frame_q <= 9'h000;
      done    <= 1'b0;
      data    <= 8'h00;
      ninth   <= 1'b0;
      stop_ok <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!rx_en) begin
        state_q <= uart0_pkg::RX_IDLE;
      end else begin
        case (state_q)
          uart0_pkg::RX_IDLE: begin
            if (prev_q && !rxd) begin
              state_q <= uart0_pkg::RX_START;
              os_q    <= 4'h0;
            end
          end
          uart0_pkg::RX_START: begin
            if (tif.os_tick) begin
              os_q <= os_q + 4'h1;
              if (os_q == 4'(`OS_MID - 1)) begin
                os_q    <= 4'h0;
                idx_q   <= 4'h0;
                state_q <= rxd ? uart0_pkg::RX_IDLE : uart0_pkg::RX_BITS;
              end
            end
          end
          uart0_pkg::RX_BITS: begin
            if (tif.os_tick) begin
              os_q <= os_q + 4'h1;
              if (os_q == 4'(`OS_PER_BIT - 1)) begin
                idx_q <= idx_q + 4'h1;
                if (idx_q == last_idx) begin
                  // Reported at the middle of the stop bit.
                  done    <= 1'b1;
                  data    <= frame_q[7:0];
                  ninth   <= tif.mode[1] ? frame_q[8] : rxd;
                  stop_ok <= rxd;
                  state_q <= uart0_pkg::RX_IDLE;
                end else begin
                  frame_q[idx_q] <= rxd;
                end
              end
            end
          end
          default: state_q <= uart0_pkg::RX_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** logic/serial_port0.sv ***
// Serial port 0 with register file, shift engine and station address filter.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uart0_consts.svh"

module serial_port0 (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        timer_tick,
  output logic             txd,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             uart_irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic                    mode_hi_q;
  logic                    mode_lo_q;
  logic                    mp_q;
  logic                    ren_q;
  logic                    tb8_q;
  logic                    rb8_q;
  logic                    ti_q;
  logic                    ri_q;
  logic                    fe_q;
  logic                    doubler_q;
  logic                    fce_q;
  logic [7:0]              ie_q;
  logic [7:0]              station_address_q;
  logic [7:0]              smask_q;
  logic [7:0]              rx_buf_q;
  uart0_pkg::mode_t        mode;
  uart0_pkg::shift_state_e sh_q;
  logic [7:0]              shift_q;
  logic [10:0]             tx_frame_q;
  logic [3:0]              cnt_q;
  logic [3:0]              os_q;
  logic                    phase_q;
  logic                    wr_ctrl;
  logic                    wr_buf;
  logic                    ti_set;
  logic                    m0_rx_done;
  logic                    async_rx_en;
  logic                    rx_frame_done;
  logic [7:0]              rx_frame_data;
  logic                    rx_frame_ninth;
  logic                    rx_frame_stop_ok;
  logic                    rx_accept;
  logic                    rx_load;
  logic [7:0]              rx_load_data;
  logic                    fe_set;
  logic [3:0]              stop_idx;

  serial_timing_if tif ();

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Address decode shared by the write strobes and the read mux.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Masked station compare; a zero mask matches every address.
  function automatic logic addr_match(input logic [7:0] d, input logic [7:0] a,
                                      input logic [7:0] m);
    addr_match = (((d ^ a) & m) == 8'h00);
  endfunction

  assign mode     = {mode_hi_q, mode_lo_q};
  assign stop_idx = (mode == 2'b01) ? 4'd9 : 4'd10;
  assign wr_ctrl  = reg_wr && hit(reg_addr, `OFS_UART_CONTROL);
  assign wr_buf   = reg_wr && hit(reg_addr, `OFS_UART_BUFFER);

  // --------------------------------------------------------------------------
  // Timing and receiver
  // --------------------------------------------------------------------------

  assign tif.mode       = mode;
  assign tif.mp_bit     = mp_q;
  assign tif.doubler    = doubler_q;
  assign tif.timer_tick = timer_tick;

  uart0_baud u_baud (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tif     (tif.gen)
  );

  assign async_rx_en = ren_q && (mode != 2'b00);

  uart0_rx u_rx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tif     (tif.rx),
    .rx_en   (async_rx_en),
    .rxd     (rxd_in),
    .done    (rx_frame_done),
    .data    (rx_frame_data),
    .ninth   (rx_frame_ninth),
    .stop_ok (rx_frame_stop_ok)
  );

  // In modes 1 to 3 a byte still unread in the buffer blocks the next one, so it is
  // never overwritten; the later byte is lost. In mode 0 the next shift starts as the
  // done flag sets, and its byte overwrites the buffer.
  // ninth bit filter
  always_comb begin
    if (!mp_q) begin
      rx_accept = 1'b1;
    end else if (mode == 2'b01) begin
      rx_accept = rx_frame_stop_ok;
    end else begin
      rx_accept = rx_frame_ninth && addr_match(rx_frame_data, station_address_q, smask_q);
    end
  end

  assign rx_load      = m0_rx_done || (rx_frame_done && rx_accept && !ri_q);
  assign rx_load_data = m0_rx_done ? shift_q : rx_frame_data;

  assign fe_set = rx_frame_done && !rx_frame_stop_ok && fce_q;

  // --------------------------------------------------------------------------
  // Shift engine
  // --------------------------------------------------------------------------

  // Mode 0 shifts both ways on the receive pin with the clock on the
  // transmit pin; the asynchronous transmitter runs beside the receiver.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q       <= uart0_pkg::SH_IDLE;
      shift_q    <= `RST_BYTE;
      tx_frame_q <= `RST_TX_FRAME;
      cnt_q      <= 4'h0;
      os_q       <= 4'h0;
      phase_q    <= 1'b0;
      ti_set     <= 1'b0;
      m0_rx_done <= 1'b0;
    end else begin
      ti_set     <= 1'b0;
      m0_rx_done <= 1'b0;
      case (sh_q)
        uart0_pkg::SH_IDLE: begin
          cnt_q   <= 4'h0;
          os_q    <= 4'h0;
          phase_q <= 1'b0;
          if (wr_buf) begin
            if (mode == 2'b00) begin
              shift_q <= reg_wdata;
              sh_q    <= uart0_pkg::SH_M0_TX;
            end else begin
              tx_frame_q <= {1'b1, (mode[1] ? tb8_q : 1'b1), reg_wdata, 1'b0};
              sh_q       <= uart0_pkg::SH_ASYNC_TX;
            end
          end else if (mode == 2'b00 && ren_q && !ri_q) begin
            sh_q <= uart0_pkg::SH_M0_RX;
          end
        end
        uart0_pkg::SH_M0_TX,
        uart0_pkg::SH_M0_RX: begin
          if (tif.half_tick) begin
            phase_q <= ~phase_q;
            if (!phase_q) begin
              if (sh_q == uart0_pkg::SH_M0_RX) begin
                shift_q <= {rxd_in, shift_q[7:1]};
              end
            end else begin
              if (sh_q == uart0_pkg::SH_M0_TX) begin
                shift_q <= {1'b1, shift_q[7:1]};
              end
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == 4'd7) begin
                ti_set     <= (sh_q == uart0_pkg::SH_M0_TX);
                m0_rx_done <= (sh_q == uart0_pkg::SH_M0_RX);
                sh_q       <= uart0_pkg::SH_IDLE;
              end
            end
          end
        end
        uart0_pkg::SH_ASYNC_TX: begin
          if (tif.os_tick) begin
            os_q <= os_q + 4'h1;
            if (os_q == 4'(`OS_PER_BIT - 1)) begin
              tx_frame_q <= {1'b1, tx_frame_q[10:1]};
              cnt_q      <= cnt_q + 4'h1;
              ti_set <= (cnt_q + 4'h1 == stop_idx);
              if (cnt_q == stop_idx) begin
                sh_q <= uart0_pkg::SH_IDLE;
              end
            end
          end
        end
        default: sh_q <= uart0_pkg::SH_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd     <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else begin
      case (sh_q)
        uart0_pkg::SH_M0_TX,
        uart0_pkg::SH_M0_RX: txd <= phase_q;
        uart0_pkg::SH_ASYNC_TX: txd <= tx_frame_q[0];
        default: txd <= 1'b1;
      endcase
      rxd_out <= (sh_q == uart0_pkg::SH_M0_TX) ? shift_q[0] : 1'b1;
      rxd_oe  <= (sh_q == uart0_pkg::SH_M0_TX);
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------

  // Control bits; hardware set wins over a software clear in the same cycle.
  // shared top bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_hi_q <= 1'b0;
      mode_lo_q <= 1'b0;
      mp_q      <= 1'b0;
      ren_q     <= 1'b0;
      tb8_q     <= 1'b0;
      fe_q      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_lo_q <= reg_wdata[`CTL_MODE_LO];
        mp_q      <= reg_wdata[`CTL_MP];
        ren_q     <= reg_wdata[`CTL_REN];
        tb8_q     <= reg_wdata[`CTL_TB8];
        if (!fce_q) begin
          mode_hi_q <= reg_wdata[`CTL_MODE_HI];
        end
      end
      if (fe_set) begin
        fe_q <= 1'b1;
      end else if (wr_ctrl && fce_q) begin
        fe_q <= reg_wdata[`CTL_MODE_HI];
      end
    end
  end

  // Done flags and received data.
  // receive ninth bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ti_q     <= 1'b0;
      ri_q     <= 1'b0;
      rb8_q    <= 1'b0;
      rx_buf_q <= `RST_BYTE;
    end else begin
      ti_q <= ti_set || (wr_ctrl ? reg_wdata[`CTL_TI] : ti_q);
      ri_q <= rx_load || (wr_ctrl ? reg_wdata[`CTL_RI] : ri_q);
      if (rx_load) begin
        rx_buf_q <= rx_load_data;
        if (!m0_rx_done) begin
          rb8_q <= rx_frame_ninth;
        end
      end else if (wr_ctrl) begin
        rb8_q <= reg_wdata[`CTL_RB8];
      end
    end
  end

  // Plain read/write registers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      doubler_q <= 1'b0;
      fce_q     <= 1'b0;
      ie_q      <= `RST_BYTE;
      station_address_q   <= `RST_BYTE;
      smask_q   <= `RST_BYTE;
    end else if (reg_wr) begin
      if (hit(reg_addr, `OFS_POWER_CONTROL)) begin
        doubler_q <= reg_wdata[`PWR_DOUBLER];
        fce_q     <= reg_wdata[`PWR_FCE];
      end
      if (hit(reg_addr, `OFS_IRQ_ENABLE)) begin
        ie_q <= reg_wdata;
      end
      if (hit(reg_addr, `OFS_STATION_ADDR)) begin
        station_address_q <= reg_wdata;
      end
      if (hit(reg_addr, `OFS_STATION_MASK)) begin
        smask_q <= reg_wdata;
      end
    end
  end

  // Read data stand for one cycle only; unmapped addresses read zero.
  // buffer read side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (hit(reg_addr, `OFS_UART_CONTROL)) begin
      reg_rdata <= {(fce_q ? fe_q : mode_hi_q), mode_lo_q, mp_q, ren_q,
                    tb8_q, rb8_q, ti_q, ri_q};
    end else if (hit(reg_addr, `OFS_UART_BUFFER)) begin
      reg_rdata <= rx_buf_q;
    end else if (hit(reg_addr, `OFS_POWER_CONTROL)) begin
      reg_rdata <= {doubler_q, fce_q, 6'h00};
    end else if (hit(reg_addr, `OFS_IRQ_ENABLE)) begin
      reg_rdata <= ie_q;
    end else if (hit(reg_addr, `OFS_STATION_ADDR)) begin
      reg_rdata <= station_address_q;
    end else if (hit(reg_addr, `OFS_STATION_MASK)) begin
      reg_rdata <= smask_q;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Interrupt request toward the processor; power fail is handled elsewhere.
  // port enable gate
  assign uart_irq = (ti_q || ri_q) && ie_q[`IE_UART] && ie_q[`IE_GLOBAL];

endmodule

`default_nettype wire

// *** dv/serial_port0_asserts.sv ***
// Concurrent checks on the serial port 0 register bus and pins.
`timescale 1ns/1ps
`default_nettype none
module serial_port0_asserts (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       txd,
  input wire logic       rxd_oe,
  input wire logic       uart_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0]  ie_q, sa_q, ctl_q, pwr_q;
  logic [10:0] busy_q;
  logic        m2;
  assign m2 = (ctl_q[7:6] == 2'b10);
  // Shadows of software writes; mode high is only written with frame check off.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ie_q, sa_q, ctl_q, pwr_q} <= 32'h0000_0000;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h87: pwr_q <= reg_wdata;
        8'h98: ctl_q <= {pwr_q[6] ? ctl_q[7] : reg_wdata[7], reg_wdata[6:0]};
        8'hA8: ie_q <= reg_wdata;
        8'hA9: sa_q <= reg_wdata;
        default: ;
      endcase
    end
  end
  // Frame window of one slow mode 2 frame; writes inside it are refused.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 11'h000;
    end else if (reg_wr && reg_addr == 8'h99 && busy_q == 11'h000) begin
      busy_q <= 11'h2D0;
    end else if (busy_q != 11'h000) begin
      busy_q <= busy_q - 11'h001;
    end
  end
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h87, 8'h98,
    8'h99, 8'hA8, 8'hA9, 8'hB9}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ie_readback: assert property (reg_rd && reg_addr == 8'hA8 |=> reg_rdata == ie_q)
    else $error("enable register readback wrong");
  a_addr_readback: assert property (reg_rd && reg_addr == 8'hA9 |=> reg_rdata == sa_q)
    else $error("station address readback wrong");
  a_ctl_readback: assert property (reg_rd && reg_addr == 8'h98 |=>
    reg_rdata[6:3] == ctl_q[6:3] && (pwr_q[6] || reg_rdata[7] == ctl_q[7]))
    else $error("control readback wrong");
  a_irq_gated: assert property (uart_irq |-> ie_q[7] && ie_q[4])
    else $error("interrupt while not enabled");
  a_irq_flags: assert property (reg_rd && reg_addr == 8'h98 |=>
    $past(uart_irq) == ((|reg_rdata[1:0]) && ie_q[7] && ie_q[4]))
    else $error("interrupt does not follow flags");
  a_tx_start: assert property (reg_wr && reg_addr == 8'h99 && busy_q == 11'h000
    && m2 |-> ##[1:16] !txd)
    else $error("no start bit after buffer write");
  a_pins_idle: assert property (m2 && busy_q == 11'h000 |-> txd && !rxd_oe)
    else $error("pins not idle outside a frame");
endmodule
`default_nettype wire

// *** dv/remote_station.sv ***
// Model of the remote serial station on the far side of the link.
`timescale 1ns/1ps
`default_nettype none
module remote_station (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      line
);
  // The line has a pull-up, so it rests high outside frames.
  initial line = 1'b1;
  task automatic send(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (bt) @(posedge ref_clk);
    end
    line <= 1'b1;
  endtask
  // frame from transmit pin, sampled mid-bit so edge jitter is harmless.
  task automatic grab(output logic [10:0] f, input int bt);
    f = 11'h000;
    for (int t = 0; t < 2000 && txd === 1'b1; t++) @(posedge ref_clk);
    repeat (bt / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd;
      repeat (bt) @(posedge ref_clk);
    end
  endtask
  // mode 0 byte onto receive pin; each bit moves on as the shift clock rises.
  task automatic shift(input logic [7:0] b);
    line <= b[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge txd);
      line <= b[i];
    end
    @(posedge txd);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** dv/test_serial_port0.sv ***
// Self-checking bench for serial port 0.
`timescale 1ns/1ps
`default_nettype none
module test_serial_port0;
  logic        ref_clk, rst_n, reg_wr, reg_rd, timer_tick;
  logic        txd, rxd_out, rxd_oe, uart_irq, st_line, rxd_w;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, c, v, d, sa, m;
  logic [10:0] fr;
  logic [7:0]  al [5] = '{8'h98, 8'h99, 8'hA8, 8'hA9, 8'h55};
  int          bad_count, cmp_count, cyc, sd;
  time         t0;
  // The port drives the receive wire only in shift mode.
  assign rxd_w = rxd_oe ? rxd_out : st_line;
  serial_port0 dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer_tick, .txd, .rxd_in(rxd_w), .rxd_out, .rxd_oe, .uart_irq);
  remote_station st (.ref_clk, .txd, .line(st_line));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Timer overflow every fourth clock; the ceiling cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    timer_tick <= (cyc % 4 == 0);
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end
  // Bus tasks leave one idle edge so no strobe is assigned twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address filter of modes 2 and 3.
  function automatic logic exp_ri(logic mp, logic n9, logic [7:0] x, logic [7:0] s,
                                  logic [7:0] k);
    return !mp || (n9 && ((x ^ s) & k) == 8'h00);
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, timer_tick} = 4'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    cyc = 0;
    bad_count = 0;
    cmp_count = 0;
    sd = $urandom(71403);
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (al[i]) begin
      rd(al[i], v);
      chk(11'(v), 11'h000);
    end
    $display("reset test done");
    // Mode 2 at both rates, then mode 3; a second write mid-frame must be ignored.
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      wr(8'h87, {k[1], 7'h00});
      wr(8'h98, {1'b1, 1'(k == 3), 2'b00, k[0], 3'h0});
      wr(8'h99, d);
      wr(8'h99, ~d);
      st.grab(fr, (k == 2) ? 32 : 64);
      chk(fr, {1'b1, k[0], d, 1'b0});
      rd(8'h98, v);
      chk(11'(v[1]), 11'h001);
    end
    for (int j = 0; j < 4; j++) begin
      wr(8'hA8, {j[1], 2'b00, j[0], 4'h0});
      chk(11'(uart_irq), 11'(j == 3));
    end
    $display("transmit test done");
    wr(8'h87, 8'h00);
    for (int k = 0; k < 12; k++) begin
      d = 8'($urandom);
      sa = 8'($urandom);
      m = (k < 4) ? 8'h00 : 8'($urandom);
      if (k == 7) d = sa;
      wr(8'hA9, sa);
      wr(8'hB9, m);
      wr(8'h98, {2'b10, k[0], 1'(k != 8), 4'h0});
      st.send({1'b1, k[1], d, 1'b0}, 11, 64);
      rd(8'h98, c);
      chk(11'(c[0]), 11'(k != 8 && exp_ri(k[0], k[1], d, sa, m)));
      if (c[0] === 1'b1) begin
        rd(8'h99, v);
        chk(11'({c[2], v}), 11'({k[1], d}));
      end
    end
    $display("filter test done");
    wr(8'h87, 8'h40);
    wr(8'h98, 8'h10);
    for (int s = 0; s < 2; s++) begin
      st.send({s[0], 1'b1, 8'($urandom), 1'b0}, 11, 64);
      rd(8'h98, c);
      chk(11'(c[7]), 11'h001);
    end
    wr(8'h98, 8'h10);
    rd(8'h98, c);
    chk(11'(c[7]), 11'h000);
    wr(8'h87, 8'h00);
    rd(8'h98, c);
    chk(11'(c[7:6]), 11'h002);
    $display("frame error test done");
    for (int s = 0; s < 2; s++) begin
      wr(8'h98, 8'h70);
      st.send({1'b1, s[0], 8'($urandom), 1'b0}, 10, 128);
      rd(8'h98, c);
      chk(11'(c[0]), 11'(s));
    end
    $display("mode 1 test done");
    // Mode 0 transmit at both shift clocks; data sampled as the clock rises.
    for (int s = 0; s < 2; s++) begin
      d = 8'($urandom);
      wr(8'h98, {2'b00, s[0], 5'h00});
      wr(8'h99, d);
      for (int i = 0; i < 8; i++) begin
        @(posedge txd);
        if (i == 0) t0 = $time;
        v[i] = rxd_w;
      end
      chk(11'(($time - t0) / 10), 11'(s ? 28 : 84));
      chk(11'(v), 11'(d));
      repeat (16) @(posedge ref_clk);
      rd(8'h98, c);
      chk(11'(c[1]), 11'h001);
    end
    // Mode 0 receive starts by itself once enabled with the done flag clear.
    d = 8'($urandom);
    wr(8'h98, 8'h30);
    st.shift(d);
    repeat (4) @(posedge ref_clk);
    rd(8'h98, c);
    rd(8'h99, v);
    chk(11'({c[0], v}), 11'({1'b1, d}));
    $display("mode 0 test done");
    summarize();
  end
endmodule
bind serial_port0 serial_port0_asserts chk_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .txd, .rxd_oe, .uart_irq);
`default_nettype wire
